// File: logic/ptsp_pkg.sv
// Shared constants and types of the pitch track smoothing pipeline
package ptsp_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int PITCH_W = 8;
    localparam int ENERGY_W = 16;
    localparam int IDX_W = 5;
    localparam int ACC_W = 9;

    // ************************************************************
    // Stage geometry
    // ************************************************************
    localparam int FIRST_STAGE_LOOKAHEAD = 8;
    localparam int FIRST_STAGE_HISTORY = 10;
    localparam int FIRST_STAGE_LENGTH = FIRST_STAGE_LOOKAHEAD + FIRST_STAGE_HISTORY + 1;
    localparam int SECOND_STAGE_LOOKAHEAD = 1;
    localparam int SECOND_STAGE_LENGTH = SECOND_STAGE_LOOKAHEAD + 1 + 1;
    localparam int THIRD_STAGE_LOOKAHEAD = 2;
    localparam int THIRD_STAGE_LENGTH = THIRD_STAGE_LOOKAHEAD + 2 + 1;
    localparam int TOTAL_DELAY =
        FIRST_STAGE_LOOKAHEAD + SECOND_STAGE_LOOKAHEAD + THIRD_STAGE_LOOKAHEAD;
    localparam int CLASS_HIST_LENGTH = TOTAL_DELAY + 2;
    localparam logic [IDX_W-1:0] EXAMINED_IDX = 5'h0A;
    localparam logic [IDX_W-1:0] NEWEST_IDX = 5'h12;
    localparam logic [IDX_W-1:0] OLDEST_IDX = 5'h00;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [PITCH_W-1:0] PITCH_RESET = 8'h00;
    localparam logic signed [ENERGY_W-1:0] ENERGY_RESET = 16'hFFCE;

    // ************************************************************
    // Similarity factors as ratios: 1,28 = 32/25 and 1,4 = 7/5
    // ************************************************************
    localparam logic [13:0] SIM_ADJ_NUM = 14'h0020;
    localparam logic [13:0] SIM_ADJ_DEN = 14'h0019;
    localparam logic [13:0] SIM_TWO_NUM = 14'h0007;
    localparam logic [13:0] SIM_TWO_DEN = 14'h0005;

    // ************************************************************
    // Buffering
    // ************************************************************
    localparam int FIFO_DEPTH = 32;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        VC_NON_SPEECH = 2'h0,
        VC_UNVOICED = 2'h1,
        VC_MIXED = 2'h2,
        VC_FULLY = 2'h3
    } ptsp_class_type;

    typedef struct packed {
        logic [PITCH_W-1:0] pitch;
        logic signed [ENERGY_W-1:0] frame_log_energy;
        ptsp_class_type voicing_class;
    } ptsp_frame_type;

    typedef struct packed {
        logic [PITCH_W-1:0] pitch;
        ptsp_class_type corrected_voicing_class;
    } ptsp_result_type;

    localparam int FIFO_WIDTH = $bits(ptsp_frame_type);

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_EVAL = 9'h002,
        ST_OLD = 9'h004,
        ST_NEW = 9'h008,
        ST_SCALE = 9'h010,
        ST_MUL = 9'h020,
        ST_DIVM = 9'h040,
        ST_DIV = 9'h080,
        ST_PUSH = 9'h100
    } ptsp_state_type;

endpackage : ptsp_pkg

// File: logic/ptsp_fifo.sv
// Synchronous FIFO buffering input frames ahead of the pitch tracker
`timescale 1ns/10ps
module ptsp_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [CW-1:0] count_ff;
    logic [CW-1:0] nxt_count;
    logic ready_ff;
    logic wr_en;
    logic rd_en;

    assign wr_en = in_valid && ready_ff;
    assign rd_en = out_valid && out_ready;
    assign nxt_count = count_ff + CW'(wr_en) - CW'(rd_en);
    assign in_ready = ready_ff;
    assign out_valid = (count_ff != '0);
    assign out_data = mem[rd_ptr_ff];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            ready_ff <= 1'b0;
        end
        else
        begin
            wr_ptr_ff <= wr_en ? PW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
            rd_ptr_ff <= rd_en ? PW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
            count_ff <= nxt_count;
            ready_ff <= (nxt_count != FULL_COUNT);
        end
    end

endmodule : ptsp_fifo

// File: logic/ptsp_pitch_tracker.sv
// Three-stage pitch tracker with voicing class correction
// Contract
// - Three pitch stages, then voicing class correction
// - Stage length is look-ahead plus history plus one
// - New stage output enters newest end, oldest drops
// - First stage: 8 ahead, 10 back, 19 entries
// - Second stage: one ahead, one back, three entries
// - Third stage: two ahead, two back, five entries
// - Output lags newest input by eleven frames
// - Reset clears all pitch stage entries
// - Reset loads every energy entry with minus fifty
// - Zero pitch means unvoiced; class returned corrected
// - Fully and mixed voiced count as voiced
// - Newest at highest index, energy shifts in step
// - First stage examines entry ten, feeds stage two
// - Zero examined pitch gives zero output
// - Isolated voiced frame becomes unvoiced
// - Two-frame run: keep if similar, else zero
// - Run bounded by zeros, eight newer, ten older
// - Reference from run; output scaled by integer
// - Similar means within factor either way
// - Factor 1,28 adjacent, 1,4 two apart; the code declares 1,4 but never applies it
`timescale 1ns/10ps
module ptsp_pitch_tracker (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // New frame from upstream
    input wire logic frame_valid,
    input wire ptsp_pkg::ptsp_frame_type frame_in,
    output logic frame_ready,
    // Corrected result
    output logic result_valid,
    output ptsp_pkg::ptsp_result_type result
);

    // ************************************************************
    // Declarations
    // ************************************************************
    localparam int L1 = ptsp_pkg::FIRST_STAGE_LENGTH;
    localparam int L2 = ptsp_pkg::SECOND_STAGE_LENGTH;
    localparam int L3 = ptsp_pkg::THIRD_STAGE_LENGTH;
    localparam int LC = ptsp_pkg::CLASS_HIST_LENGTH;
    localparam int PW = ptsp_pkg::PITCH_W;
    localparam int AW = ptsp_pkg::ACC_W;
    localparam int EX = int'(ptsp_pkg::EXAMINED_IDX);

    ptsp_pkg::ptsp_frame_type fifo_data;
    ptsp_pkg::ptsp_state_type state_ff;
    logic fifo_valid;
    logic pop;
    logic in_voiced;
    logic [PW-1:0] in_pitch;
    logic [PW-1:0] s1p_ff [0:L1-1];
    logic signed [ptsp_pkg::ENERGY_W-1:0] s1e_ff [0:L1-1];
    logic [PW-1:0] s2p_ff [0:L2-1];
    logic [PW-1:0] s3p_ff [0:L3-1];
    ptsp_pkg::ptsp_class_type vc_ff [0:LC-1];
    logic [ptsp_pkg::IDX_W-1:0] idx_ff;
    logic [AW-1:0] acc_ff;
    logic [PW-1:0] mul_ff;
    logic [PW-1:0] quo_ff;
    logic [PW-1:0] best_p_ff;
    logic signed [ptsp_pkg::ENERGY_W-1:0] best_e_ff;
    logic have_best_ff;
    logic [PW-1:0] s1_out_ff;
    logic result_valid_ff;
    ptsp_pkg::ptsp_result_type result_ff;
    logic [PW-1:0] cur_p;
    logic [PW-1:0] old_p;
    logic [PW-1:0] new_p;
    logic pair_old;
    logic pair_new;
    logic take_best;
    logic [AW-1:0] step_p;
    logic [AW-1:0] tgt_p;
    logic [AW-1:0] over;
    logic [AW-1:0] under;
    logic pick_lower;
    logic [AW-1:0] mul_pick;
    ptsp_pkg::ptsp_class_type vc_fix;

    // Two positive pitches within num/den of each other
    function automatic logic similar(
        input logic [PW-1:0] a,
        input logic [PW-1:0] b,
        input logic [13:0] num,
        input logic [13:0] den
    );
        logic [13:0] wa;
        logic [13:0] wb;
        wa = {6'h00, a};
        wb = {6'h00, b};
        similar = (a != '0) && (b != '0) && (wa * num >= wb * den)
            && (wb * num >= wa * den);
    endfunction : similar

    // ************************************************************
    // Input buffering
    // ************************************************************
    ptsp_fifo #(
        .WIDTH(ptsp_pkg::FIFO_WIDTH),
        .DEPTH(ptsp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .in_valid(frame_valid),
        .in_data(frame_in),
        .in_ready(frame_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(state_ff == ptsp_pkg::ST_IDLE)
    );

    // One frame leaves the FIFO only while the tracker is idle
    assign pop = fifo_valid && (state_ff == ptsp_pkg::ST_IDLE);

    // Unvoiced and non-speech frames enter with zero pitch
    assign in_voiced = (fifo_data.voicing_class == ptsp_pkg::VC_MIXED)
        || (fifo_data.voicing_class == ptsp_pkg::VC_FULLY);
    assign in_pitch = in_voiced ? fifo_data.pitch : '0;

    // ************************************************************
    // First stage buffers
    // ************************************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < L1; i++)
            begin
                s1p_ff[i] <= ptsp_pkg::PITCH_RESET;
                s1e_ff[i] <= ptsp_pkg::ENERGY_RESET;
            end
        end
        else if (pop)
        begin
            for (int i = 0; i < L1 - 1; i++)
            begin
                s1p_ff[i] <= s1p_ff[i+1];
                s1e_ff[i] <= s1e_ff[i+1];
            end
            s1p_ff[L1-1] <= in_pitch;
            s1e_ff[L1-1] <= fifo_data.frame_log_energy;
        end
    end

    // ************************************************************
    // First stage decision
    // ************************************************************
    assign cur_p = s1p_ff[EX];
    assign old_p = s1p_ff[EX-1];
    assign new_p = s1p_ff[EX+1];
    assign pair_old = (old_p != '0) && (new_p == '0) && (s1p_ff[EX-2] == '0);
    assign pair_new = (new_p != '0) && (old_p == '0) && (s1p_ff[EX+2] == '0);

    // Highest-energy run member other than the examined frame
    assign take_best = !have_best_ff || (s1e_ff[idx_ff] > best_e_ff);

    // Integer scaling search: multiples of step approach target
    assign step_p = (state_ff == ptsp_pkg::ST_MUL) ? {1'b0, cur_p} : {1'b0, best_p_ff};
    assign tgt_p = (state_ff == ptsp_pkg::ST_MUL) ? {1'b0, best_p_ff} : {1'b0, cur_p};
    assign over = acc_ff - tgt_p;
    assign under = tgt_p - (acc_ff - step_p);
    assign pick_lower = (mul_ff > 8'h01) && (under < over);
    assign mul_pick = pick_lower ? acc_ff - step_p : acc_ff;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= ptsp_pkg::ST_IDLE;
            idx_ff <= '0;
            acc_ff <= '0;
            mul_ff <= '0;
            quo_ff <= '0;
            best_p_ff <= '0;
            best_e_ff <= '0;
            have_best_ff <= 1'b0;
            s1_out_ff <= '0;
        end
        else
        begin
            case (state_ff)
                ptsp_pkg::ST_IDLE:
                begin
                    if (pop)
                    begin
                        state_ff <= ptsp_pkg::ST_EVAL;
                    end
                end
                ptsp_pkg::ST_EVAL:
                begin
                    state_ff <= ptsp_pkg::ST_PUSH;
                    if (cur_p == '0)
                    begin
                        s1_out_ff <= '0;
                    end
                    else if ((old_p == '0) && (new_p == '0))
                    begin
                        s1_out_ff <= '0;
                    end
                    else if (pair_old)
                    begin
                        s1_out_ff <= similar(old_p, cur_p, ptsp_pkg::SIM_ADJ_NUM,
                            ptsp_pkg::SIM_ADJ_DEN) ? cur_p : '0;
                    end
                    else if (pair_new)
                    begin
                        s1_out_ff <= similar(cur_p, new_p, ptsp_pkg::SIM_ADJ_NUM,
                            ptsp_pkg::SIM_ADJ_DEN) ? cur_p : '0;
                    end
                    else
                    begin
                        idx_ff <= ptsp_pkg::EXAMINED_IDX - 5'h01;
                        have_best_ff <= 1'b0;
                        state_ff <= ptsp_pkg::ST_OLD;
                    end
                end
                ptsp_pkg::ST_OLD:
                begin
                    // Walk older members until a zero or the oldest entry
                    if (s1p_ff[idx_ff] != '0)
                    begin
                        if (take_best)
                        begin
                            best_p_ff <= s1p_ff[idx_ff];
                            best_e_ff <= s1e_ff[idx_ff];
                            have_best_ff <= 1'b1;
                        end
                    end
                    if ((s1p_ff[idx_ff] == '0) || (idx_ff == ptsp_pkg::OLDEST_IDX))
                    begin
                        idx_ff <= ptsp_pkg::EXAMINED_IDX + 5'h01;
                        state_ff <= ptsp_pkg::ST_NEW;
                    end
                    else
                    begin
                        idx_ff <= idx_ff - 5'h01;
                    end
                end
                ptsp_pkg::ST_NEW:
                begin
                    // Walk newer members until a zero or the newest entry
                    if (s1p_ff[idx_ff] != '0)
                    begin
                        if (take_best)
                        begin
                            best_p_ff <= s1p_ff[idx_ff];
                            best_e_ff <= s1e_ff[idx_ff];
                            have_best_ff <= 1'b1;
                        end
                    end
                    if ((s1p_ff[idx_ff] == '0) || (idx_ff == ptsp_pkg::NEWEST_IDX))
                    begin
                        state_ff <= ptsp_pkg::ST_SCALE;
                    end
                    else
                    begin
                        idx_ff <= idx_ff + 5'h01;
                    end
                end
                ptsp_pkg::ST_SCALE:
                begin
                    mul_ff <= 8'h01;
                    if (best_p_ff == cur_p)
                    begin
                        s1_out_ff <= cur_p;
                        state_ff <= ptsp_pkg::ST_PUSH;
                    end
                    else if (best_p_ff > cur_p)
                    begin
                        acc_ff <= {1'b0, cur_p};
                        state_ff <= ptsp_pkg::ST_MUL;
                    end
                    else
                    begin
                        acc_ff <= {1'b0, best_p_ff};
                        state_ff <= ptsp_pkg::ST_DIVM;
                    end
                end
                ptsp_pkg::ST_MUL:
                begin
                    if (acc_ff >= tgt_p)
                    begin
                        // Nearest multiple, held within the pitch range
                        s1_out_ff <= mul_pick[AW-1] ? 8'hFF : mul_pick[PW-1:0];
                        state_ff <= ptsp_pkg::ST_PUSH;
                    end
                    else
                    begin
                        acc_ff <= acc_ff + step_p;
                        mul_ff <= mul_ff + 8'h01;
                    end
                end
                ptsp_pkg::ST_DIVM:
                begin
                    if (acc_ff >= tgt_p)
                    begin
                        mul_ff <= pick_lower ? mul_ff - 8'h01 : mul_ff;
                        acc_ff <= {1'b0, cur_p};
                        quo_ff <= '0;
                        state_ff <= ptsp_pkg::ST_DIV;
                    end
                    else
                    begin
                        acc_ff <= acc_ff + step_p;
                        mul_ff <= mul_ff + 8'h01;
                    end
                end
                ptsp_pkg::ST_DIV:
                begin
                    // Pitch divided by the chosen integer
                    if (acc_ff >= {1'b0, mul_ff})
                    begin
                        acc_ff <= acc_ff - {1'b0, mul_ff};
                        quo_ff <= quo_ff + 8'h01;
                    end
                    else
                    begin
                        s1_out_ff <= quo_ff;
                        state_ff <= ptsp_pkg::ST_PUSH;
                    end
                end
                ptsp_pkg::ST_PUSH:
                begin
                    state_ff <= ptsp_pkg::ST_IDLE;
                end
                default:
                begin
                    state_ff <= ptsp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Second and third stage buffers
    // ************************************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < L2; i++)
            begin
                s2p_ff[i] <= ptsp_pkg::PITCH_RESET;
            end
            for (int i = 0; i < L3; i++)
            begin
                s3p_ff[i] <= ptsp_pkg::PITCH_RESET;
            end
        end
        else if (state_ff == ptsp_pkg::ST_PUSH)
        begin
            for (int i = 0; i < L2 - 1; i++)
            begin
                s2p_ff[i] <= s2p_ff[i+1];
            end
            s2p_ff[L2-1] <= s1_out_ff;
            for (int i = 0; i < L3 - 1; i++)
            begin
                s3p_ff[i] <= s3p_ff[i+1];
            end
            // The second stage middle after this push is its current newest
            s3p_ff[L3-1] <= s2p_ff[L2-1];
        end
    end

    // ************************************************************
    // Voicing class history, aligned to the output frame
    // ************************************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < LC; i++)
            begin
                vc_ff[i] <= ptsp_pkg::VC_NON_SPEECH;
            end
        end
        else if (pop)
        begin
            for (int i = 0; i < LC - 1; i++)
            begin
                vc_ff[i] <= vc_ff[i+1];
            end
            vc_ff[LC-1] <= fifo_data.voicing_class;
        end
    end

    // A lone fully voiced frame after mixed voicing is demoted
    always_comb
    begin
        if ((vc_ff[0] == ptsp_pkg::VC_MIXED) && (vc_ff[1] == ptsp_pkg::VC_FULLY)
            && (vc_ff[2] != ptsp_pkg::VC_FULLY))
        begin
            vc_fix = ptsp_pkg::VC_MIXED;
        end
        else
        begin
            vc_fix = vc_ff[1];
        end
    end

    // ************************************************************
    // Result register
    // ************************************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            result_valid_ff <= 1'b0;
            result_ff <= '0;
        end
        else
        begin
            result_valid_ff <= (state_ff == ptsp_pkg::ST_PUSH);
            if (state_ff == ptsp_pkg::ST_PUSH)
            begin
                // Third stage middle after this push, eleven frames back
                result_ff.pitch <= s3p_ff[L3-2];
                result_ff.corrected_voicing_class <= vc_fix;
            end
        end
    end

    assign result_valid = result_valid_ff;
    assign result = result_ff;

endmodule : ptsp_pitch_tracker

// File: verification/ptsp_checker.sv
// Port checker for the pitch tracker
`timescale 1ns/10ps
module ptsp_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Frames in
    input wire logic frame_valid,
    input wire ptsp_pkg::ptsp_frame_type frame_in,
    input wire logic frame_ready,
    // Results out
    input wire logic result_valid,
    input wire ptsp_pkg::ptsp_result_type result
);
    logic [15:0] n_in_ff;
    logic [15:0] n_out_ff;
    logic [63:0] zero_ff;
    ptsp_pkg::ptsp_class_type cls_ff [64];
    logic take;
    logic old;
    logic [5:0] k;
    assign take = frame_valid && frame_ready;
    assign old = result_valid && n_out_ff > 16'h000A;
    assign k = 6'(n_out_ff - 16'h000B);
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
            n_in_ff <= 16'h0000;
        else if (take)
            n_in_ff <= n_in_ff + 16'h0001;
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
            n_out_ff <= 16'h0000;
        else if (result_valid)
            n_out_ff <= n_out_ff + 16'h0001;
    // Remember per taken frame whether it counts as unvoiced
    always_ff @(posedge clk)
        if (take)
            zero_ff[n_in_ff[5:0]] <= frame_in.pitch == 8'h00 || !frame_in.voicing_class[1];
    always_ff @(posedge clk)
        if (take)
            cls_ff[n_in_ff[5:0]] <= frame_in.voicing_class;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_pulse_single: assert property (result_valid |=> !result_valid)
        else $error("result pulse too long");
    a_result_holds: assert property ($changed(result) |-> result_valid)
        else $error("result moved without pulse");
    a_count_order: assert property (result_valid |-> n_out_ff < n_in_ff)
        else $error("result without frame");
    a_min_latency: assert property (take && n_in_ff == n_out_ff |=> !result_valid [*3])
        else $error("result too early");
    a_answer_bound: assert property (take && n_in_ff == n_out_ff |-> ##[1:600] result_valid)
        else $error("result missing");
    a_primed_zero: assert property (result_valid && !old |-> result.pitch == 8'h00)
        else $error("primed result not zero");
    a_unvoiced_zero: assert property (old && zero_ff[k] |-> result.pitch == 8'h00)
        else $error("unvoiced frame gave pitch");
    a_isolated_zero: assert property (old && n_out_ff != 16'h000B && zero_ff[k - 6'h01]
        && zero_ff[k + 6'h01] |-> result.pitch == 8'h00) else $error("isolated frame kept");
    a_class_pass: assert property (old && cls_ff[k] != ptsp_pkg::VC_FULLY
        |-> result.corrected_voicing_class == cls_ff[k]) else $error("class changed");
    c_full: cover property (!frame_ready && n_in_ff != 16'h0000);
    c_voiced: cover property (old && result.pitch != 8'h00);
    c_fix: cover property (old && result.corrected_voicing_class != cls_ff[k]);
endmodule : ptsp_checker
bind ptsp_pitch_tracker ptsp_checker chk_u (.clk, .rstn, .frame_valid, .frame_in, .frame_ready,
    .result_valid, .result);

// File: verification/ptsp_frame_source.sv
// Upstream model offering queued frames, one per strobe
`timescale 1ns/10ps
module ptsp_frame_source (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Frame handshake
    output logic frame_valid,
    output ptsp_pkg::ptsp_frame_type frame_out,
    input wire logic frame_ready
);
    ptsp_pkg::ptsp_frame_type q [$];
    function void push(ptsp_pkg::ptsp_frame_type f);
        q.push_back(f);
    endfunction : push
    // Hold the offer until taken; released data shows the inverse
    always @(posedge clk or negedge rstn)
        if (!rstn)
        begin
            frame_valid <= 1'b0;
            frame_out <= '0;
        end
        else if (!frame_valid || frame_ready)
        begin
            frame_valid <= q.size() != 0;
            frame_out <= q.size() != 0 ? q.pop_front() : ~frame_out;
        end
endmodule : ptsp_frame_source

// File: verification/ptsp_pitch_tracker_tb.sv
// Self-checking bench for the pitch tracker
`timescale 1ns/10ps
module ptsp_pitch_tracker_tb;
    localparam logic [9:0] TBL [24] = '{10'h000, 10'h0F3, 10'h001, 10'h000, 10'h0CB, 10'h0D3,
        10'h000, 10'h001, 10'h0A2, 10'h0F3, 10'h000, 10'h000, 10'h11B, 10'h11B, 10'h11B,
        10'h11B, 10'h000, 10'h169, 10'h000, 10'h142, 10'h143, 10'h142, 10'h000, 10'h000};
    logic clk = 1'b0;
    logic rstn;
    logic frame_valid;
    ptsp_pkg::ptsp_frame_type frame_in;
    ptsp_pkg::ptsp_frame_type f;
    logic frame_ready;
    logic result_valid;
    ptsp_pkg::ptsp_result_type result;
    logic [9:0] exp_q [$];
    logic [7:0] p [64];
    logic [1:0] c [64];
    logic [7:0] r;
    logic [31:0] seed = 32'h00000004;
    logic full_seen = 1'b0;
    int errors = 0;
    int n_checks = 0;
    always #20 clk = ~clk;
    ptsp_pitch_tracker dut_u (.clk, .rstn, .frame_valid, .frame_in, .frame_ready,
        .result_valid, .result);
    ptsp_frame_source src_u (.clk, .rstn, .frame_valid, .frame_out(frame_in), .frame_ready);
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [7:0] pz(int j);
        return (j < 0 || j > 63 || !c[j][1]) ? 8'h00 : p[j];
    endfunction : pz
    // Stage one outcome for runs whose longer members share one pitch
    function automatic logic [7:0] s1(int j);
        logic [7:0] a;
        logic [7:0] n;
        a = pz(j);
        n = pz(j - 1) | pz(j + 1);
        if (a == 8'h00 || n == 8'h00)
            return 8'h00;
        if ((pz(j - 1) == 8'h00 && pz(j + 2) == 8'h00) || (pz(j + 1) == 8'h00 && pz(j - 2) == 8'h00))
            return (32 * a >= 25 * n && 32 * n >= 25 * a) ? a : 8'h00;
        return a;
    endfunction : s1
    function automatic logic [1:0] ce(int j);
        if (j > 0 && c[j - 1] == 2'h2 && c[j] == 2'h3 && c[j + 1] != 2'h3)
            return 2'h2;
        return c[j];
    endfunction : ce
    task check(input logic [9:0] seen, input logic [9:0] want);
        n_checks++;
        if (seen !== want)
        begin
            errors++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task stop_test();
        $display("errors=%0d n_checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test
    always @(posedge clk)
    begin
        if (rstn && frame_ready === 1'b0 && exp_q.size() < 60)
            full_seen = 1'b1;
        if (rstn && result_valid === 1'b1)
            check(result, exp_q.size() != 0 ? exp_q.pop_front() : ~result);
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        stop_test();
    end
    initial
    begin
        rstn = 1'b0;
        r = 8'(rnd() % 200 + 20);
        for (int j = 0; j < 64; j++)
        begin
            {p[j], c[j]} = j < 24 ? TBL[j] : 10'h000;
            if (j == 1 || (j > 11 && j < 16))
                p[j] = r;
            // Fully voiced runs 100,50,100 at 25-27 and 50,100,50 at 29-31 reach the scaling loops
            if (j > 24 && j < 32 && j != 28)
                {p[j], c[j]} = (j == 26 || j == 29 || j == 31) ? 10'h0CB : 10'h193;
        end
        repeat (10) @(posedge clk);
        check(result, 10'h000);
        check({9'h000, frame_ready}, 10'h000);
        rstn <= 1'b1;
        for (int k = 0; k < 64; k++)
        begin
            exp_q.push_back(k < 11 ? 10'h000 : {s1(k - 11), ce(k - 11)});
            // Odd middle frame is scaled to the nearest multiple or fraction of its neighbours
            if (k == 37 || k == 41)
                exp_q[$] = k == 37 ? 10'h193 : 10'h0CB;
            // Lowest energy keeps the odd middle frame from being the reference
            f = {p[k], (k == 26 || k == 30) ? 16'h8000 : 16'(rnd()), c[k]};
            src_u.push(f);
        end
        for (int i = 0; i < 4000 && exp_q.size() != 0; i++)
            @(posedge clk);
        repeat (20) @(posedge clk);
        check({9'h000, full_seen}, 10'h001);
        check(10'(exp_q.size()), 10'h000);
        stop_test();
    end
endmodule : ptsp_pitch_tracker_tb
